//--- fac_defs.svh
/*
  offsets, keys, field positions, reset values and sizes of the flash area controller.
  assumes it is included by bare name from the design files.
*/
`ifndef FAC_DEFS_SVH
`define FAC_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define FAC_OFS_POWER       16'hFC00
`define FAC_OFS_COMMAND     16'hFC01
`define FAC_OFS_DATA_PORT   16'hFC02
`define FAC_OFS_UNLOCK_KEY  16'hFC03
`define FAC_OFS_SPLIT       16'hFC04
`define FAC_OFS_PTR_LO      16'hFC05
`define FAC_OFS_PTR_HI      16'hFC06

// ----------------------------------------
// fields, keys and reset values
// ----------------------------------------
`define FAC_BIT_SLEEP       6
`define FAC_BIT_INFO_EN     7
`define FAC_BIT_LATCH_CLR   3
`define FAC_BIT_PROGABLE    3
`define FAC_BIT_PROG_UNLK   2
`define FAC_BIT_DATA_UNLK   1
`define FAC_KEY_DATA        8'h2A
`define FAC_KEY_PROG        8'h29
`define FAC_KEY_LOCK        8'hAA
`define FAC_RST_SPLIT       8'h80
`define FAC_RST_BYTE        8'h00
`define FAC_ERASED_BYTE     8'hFF

// ----------------------------------------
// array geometry
// ----------------------------------------
`define FAC_FLASH_BYTES     16384
`define FAC_FLASH_AW        14
`define FAC_PAGE_BYTES      64
`define FAC_PAGE_AW         6
`define FAC_SPLIT_SHIFT     7

`endif

//--- fac_pkg.sv
/*
  types of the flash area controller: sequencer states and operation codes.
  assumes nothing from fac_defs.svh; state and operation codes are literal values.
*/
`default_nettype none

package fac_pkg;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    FAC_ST_IDLE  = 2'b00,
    FAC_ST_ERASE = 2'b01,
    FAC_ST_PROG  = 2'b10
  } fac_state_type;

  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FAC_OP_NONE       = 3'b000,
    FAC_OP_DATA_READ  = 3'b001,
    FAC_OP_DATA_WRITE = 3'b010,
    FAC_OP_DATA_ERASE = 3'b011,
    FAC_OP_SECT_ERASE = 3'b100,
    FAC_OP_PROG_READ  = 3'b101,
    FAC_OP_PROG_WRITE = 3'b110,
    FAC_OP_PROG_ERASE = 3'b111
  } fac_op_type;

endpackage

`default_nettype wire

//--- fac_flash_array.sv
/*
  flash cell array as flip-flops: one write port, one combinational read port.
  assumes the sequencer writes at most one byte per clock; cells keep their value over reset.
*/
`default_nettype none

module fac_flash_array #(
  parameter int DEPTH = 16384,
  parameter int AW    = 14
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  // non-volatile contents: deliberately not reset
  logic [7:0] cell_q [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      cell_q[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = cell_q[i_raddr];

endmodule // fac_flash_array

`default_nettype wire

//--- fac_page_latch.sv
/*
  64-byte page latch filled through the data port and copied into the array.
  assumes clear and write never come in the same cycle from the controller.
*/
`default_nettype none

`include "fac_defs.svh"

module fac_page_latch #(
  parameter int BYTES = 64,
  parameter int AW    = 6
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_clear,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  logic [7:0] byte_q [BYTES];

  // clear fills with the erased value so unwritten bytes write the erased value into their cells
  genvar g;
  for (g = 0; g < BYTES; g++) begin : g_byte
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        byte_q[g] <= `FAC_ERASED_BYTE;
      end else if (i_clear) begin
        byte_q[g] <= `FAC_ERASED_BYTE;
      end else if (i_we && (i_waddr == AW'(g))) begin
        byte_q[g] <= i_wdata;
      end
    end
  end

  assign o_rdata = byte_q[i_raddr];

endmodule // fac_page_latch

`default_nettype wire

//--- fac_flash_ctrl.sv
/*
  flash area controller: registers in the extended register space, area split,
  unlock keys, erase and page program sequencer, data port with auto-increment.
  assumes a single-cycle register bus: strobes are one-cycle pulses, read data
  returned on the clock after the read strobe; chip low-power state is a level.
*/
`default_nettype none

`include "fac_defs.svh"

// Summary of operation
// - 16K byte array, erasable and rewritable
// - erase only whole 64-byte sectors
// - program one full 64-byte page
// - area boundary moves in 128-byte steps
// - program below split*128, data above
// - split zero makes everything data area
// - sleep bit sleeps flash during idle/stop
// - code 000 none, 100 sector erase
// - 001/010/011 data read, write, erase
// - 101/110/111 program read, write, erase
// - erase done clears operation code
// - read/write code stays; port moves bytes
// - latch-clear bit empties the page latch
// - key 2AH unlocks data area
// - key AAH locks whole flash
// - lock read shows program, data flags
// - lock read bit 3 programmable unlocked
// - key 29H unlocks program area
// - pointer advances after each port access
// - data addresses are logical from zero
module fac_flash_ctrl #(
  parameter int FLASH_BYTES = `FAC_FLASH_BYTES,
  parameter int FLASH_AW    = `FAC_FLASH_AW,
  parameter int PAGE_BYTES  = `FAC_PAGE_BYTES,
  parameter int PAGE_AW     = `FAC_PAGE_AW
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_chip_lowpower,
  output logic      [7:0]  o_rdata,
  output logic             o_busy,
  output logic             o_flash_sleep
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic                sleep_en_q;
  logic                info_en_q;
  fac_pkg::fac_op_type op_q;
  logic [7:0]          data_port_q;
  logic                data_unlk_q;
  logic                prog_unlk_q;
  logic [7:0]          split_q;
  logic [13:0]         ptr_q;
  logic [7:0]          rdata_q;
  logic                sleep_q;

  fac_pkg::fac_state_type state_q;
  logic [PAGE_AW-1:0]     cnt_q;
  logic [FLASH_AW-1:0]    base_addr_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_power;
  logic wr_cmd;
  logic wr_port;
  logic wr_key;
  logic wr_split;
  logic wr_ptr_lo;
  logic wr_ptr_hi;
  logic rd_port;
  logic idle;

  assign idle      = (state_q == fac_pkg::FAC_ST_IDLE);
  assign wr_power  = i_wr && (i_addr == `FAC_OFS_POWER);
  assign wr_cmd    = i_wr && idle && (i_addr == `FAC_OFS_COMMAND);
  assign wr_port   = i_wr && idle && (i_addr == `FAC_OFS_DATA_PORT);
  assign wr_key    = i_wr && (i_addr == `FAC_OFS_UNLOCK_KEY);
  assign wr_split  = i_wr && idle && (i_addr == `FAC_OFS_SPLIT);
  assign wr_ptr_lo = i_wr && idle && (i_addr == `FAC_OFS_PTR_LO);
  assign wr_ptr_hi = i_wr && idle && (i_addr == `FAC_OFS_PTR_HI);
  assign rd_port   = i_rd && idle && (i_addr == `FAC_OFS_DATA_PORT);

  // ----------------------------------------
  // area split and address mapping
  // ----------------------------------------
  logic [14:0]         split_base;
  logic [14:0]         data_phys;
  logic                data_in_range;
  logic                prog_in_range;
  logic                phys_in_prog;
  logic                data_unlk_flag;
  logic                prog_unlk_flag;

  // boundary in 128-byte units; 80H puts the boundary at the top
  assign split_base = {split_q, 7'b000_0000};
  // logical data address rides on top of the boundary
  assign data_phys  = split_base + {1'b0, ptr_q};
  assign data_in_range = (data_phys < 15'(FLASH_BYTES));
  // a zero split leaves no program area at all
  assign prog_in_range = (split_q != 8'h00) && ({1'b0, ptr_q} < split_base);
  assign phys_in_prog  = prog_in_range;

  // flags are the bare unlock bits; whether the area exists is not checked
  assign data_unlk_flag = data_unlk_q;
  assign prog_unlk_flag = prog_unlk_q;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  fac_pkg::fac_op_type new_op;
  logic                op_ok;
  logic                new_ok;
  logic [FLASH_AW-1:0] op_addr;

  assign new_op = fac_pkg::fac_op_type'(i_wdata[2:0]);

  // current code against locks and area limits; new code checked the same way
  function automatic logic allowed(input fac_pkg::fac_op_type op);
    logic ok;
    ok = 1'b0;
    case (op)
      fac_pkg::FAC_OP_DATA_READ,
      fac_pkg::FAC_OP_DATA_WRITE,
      fac_pkg::FAC_OP_DATA_ERASE: ok = data_unlk_q && data_in_range;
      fac_pkg::FAC_OP_PROG_READ,
      fac_pkg::FAC_OP_PROG_WRITE,
      fac_pkg::FAC_OP_PROG_ERASE: ok = prog_unlk_q && prog_in_range;
      fac_pkg::FAC_OP_SECT_ERASE: ok = phys_in_prog ? prog_unlk_q : data_unlk_q;
      default:                    ok = 1'b0;
    endcase
    return ok;
  endfunction

  // processes, not assigns: the function also reads lock flags and ranges
  always_comb op_ok = allowed(op_q);
  always_comb new_ok = allowed(new_op);
  // data area codes use the mapped address, the others the pointer as is
  assign op_addr = (op_q[2] == 1'b0) ? data_phys[FLASH_AW-1:0] : ptr_q[FLASH_AW-1:0];

  logic start_erase;
  logic start_prog;

  assign start_erase = wr_cmd && new_ok &&
                       ((new_op == fac_pkg::FAC_OP_DATA_ERASE) ||
                        (new_op == fac_pkg::FAC_OP_PROG_ERASE) ||
                        (new_op == fac_pkg::FAC_OP_SECT_ERASE));
  assign start_prog  = wr_cmd && new_ok &&
                       ((new_op == fac_pkg::FAC_OP_DATA_WRITE) ||
                        (new_op == fac_pkg::FAC_OP_PROG_WRITE));

  logic [FLASH_AW-1:0] new_addr;

  assign new_addr = (new_op[2] == 1'b0) ? data_phys[FLASH_AW-1:0] : ptr_q[FLASH_AW-1:0];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic                arr_we;
  logic [FLASH_AW-1:0] arr_waddr;
  logic [7:0]          arr_wdata;
  logic [7:0]          arr_rdata;
  logic [7:0]          latch_rdata;
  logic                latch_clear;
  logic                latch_we;

  assign latch_clear = wr_cmd && i_wdata[`FAC_BIT_LATCH_CLR];
  // a latch fill and a clear in one write cannot collide: different offsets
  assign latch_we    = wr_port;

  // one byte a cycle, sector or page aligned from the captured base
  assign arr_we    = !idle;
  assign arr_waddr = {base_addr_q[FLASH_AW-1:PAGE_AW], cnt_q};
  assign arr_wdata = (state_q == fac_pkg::FAC_ST_ERASE) ? `FAC_ERASED_BYTE : latch_rdata;

  fac_flash_array #(
    .DEPTH (FLASH_BYTES),
    .AW    (FLASH_AW)
  ) u_array (
    .i_clk   (i_clk),
    .i_we    (arr_we),
    .i_waddr (arr_waddr),
    .i_wdata (arr_wdata),
    .i_raddr (op_addr),
    .o_rdata (arr_rdata)
  );

  fac_page_latch #(
    .BYTES (PAGE_BYTES),
    .AW    (PAGE_AW)
  ) u_latch (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_clear (latch_clear),
    .i_we    (latch_we),
    .i_waddr (ptr_q[PAGE_AW-1:0]),
    .i_wdata (i_wdata),
    .i_raddr (cnt_q),
    .o_rdata (latch_rdata)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q     <= fac_pkg::FAC_ST_IDLE;
      cnt_q       <= '0;
      base_addr_q <= '0;
    end else begin
      case (state_q)
        fac_pkg::FAC_ST_IDLE: begin
          cnt_q <= '0;
          if (start_erase) begin
            state_q     <= fac_pkg::FAC_ST_ERASE;
            base_addr_q <= new_addr;
          end else if (start_prog) begin
            state_q     <= fac_pkg::FAC_ST_PROG;
            base_addr_q <= new_addr;
          end
        end
        fac_pkg::FAC_ST_ERASE,
        fac_pkg::FAC_ST_PROG: begin
          cnt_q <= cnt_q + PAGE_AW'(1);
          if (cnt_q == PAGE_AW'(PAGE_BYTES - 1)) begin
            state_q <= fac_pkg::FAC_ST_IDLE;
          end
        end
        default: begin
          state_q <= fac_pkg::FAC_ST_IDLE;
        end
      endcase
    end
  end

  logic erase_done;

  assign erase_done = (state_q == fac_pkg::FAC_ST_ERASE) && (cnt_q == PAGE_AW'(PAGE_BYTES - 1));

  // ----------------------------------------
  // command register
  // ----------------------------------------
  // commands written while busy are dropped, so a clear at erase end never meets a write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_q      <= fac_pkg::FAC_OP_NONE;
      info_en_q <= 1'b0;
    end else if (erase_done) begin
      op_q <= fac_pkg::FAC_OP_NONE;
    end else if (wr_cmd) begin
      info_en_q <= i_wdata[`FAC_BIT_INFO_EN];
      // a refused erase is dropped at once; read and write codes are kept
      op_q <= (!start_erase && (new_op == fac_pkg::FAC_OP_DATA_ERASE ||
               new_op == fac_pkg::FAC_OP_PROG_ERASE || new_op == fac_pkg::FAC_OP_SECT_ERASE)) ?
              fac_pkg::FAC_OP_NONE : new_op;
    end
  end

  // ----------------------------------------
  // unlock keys
  // ----------------------------------------
  // key writes stay open while busy so software can lock behind a running erase
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_unlk_q <= 1'b0;
      prog_unlk_q <= 1'b0;
    end else if (wr_key) begin
      case (i_wdata)
        `FAC_KEY_DATA: data_unlk_q <= 1'b1;
        `FAC_KEY_PROG: prog_unlk_q <= 1'b1;
        `FAC_KEY_LOCK: begin
          data_unlk_q <= 1'b0;
          prog_unlk_q <= 1'b0;
        end
        default: begin
          data_unlk_q <= data_unlk_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // split, power and pointer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      split_q <= `FAC_RST_SPLIT;
    end else if (wr_split) begin
      // values above 80H are not guarded against
      split_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_en_q <= 1'b0;
    end else if (wr_power) begin
      sleep_en_q <= i_wdata[`FAC_BIT_SLEEP];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q <= '0;
    end else if (wr_ptr_lo) begin
      ptr_q <= {ptr_q[13:8], i_wdata};
    end else if (wr_ptr_hi) begin
      ptr_q <= {i_wdata[5:0], ptr_q[7:0]};
    end else if (wr_port || rd_port) begin
      ptr_q <= ptr_q + 14'h0001;
    end
  end

  // ----------------------------------------
  // data port and read-back
  // ----------------------------------------
  logic read_op;

  assign read_op = (op_q == fac_pkg::FAC_OP_DATA_READ) || (op_q == fac_pkg::FAC_OP_PROG_READ);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      data_port_q <= `FAC_RST_BYTE;
    end else if (wr_port) begin
      data_port_q <= i_wdata;
    end else if (rd_port) begin
      // locked or out-of-area reads return zero and leave cells untouched
      data_port_q <= (read_op && op_ok) ? arr_rdata : 8'h00;
    end
  end

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (i_addr)
      `FAC_OFS_POWER:      rd_mux[`FAC_BIT_SLEEP] = sleep_en_q;
      `FAC_OFS_COMMAND:    rd_mux = {info_en_q, 4'h0, op_q};
      `FAC_OFS_DATA_PORT:  rd_mux = (rd_port && read_op && op_ok) ? arr_rdata : data_port_q;
      `FAC_OFS_UNLOCK_KEY: begin
        rd_mux[`FAC_BIT_PROGABLE]  = data_unlk_flag || prog_unlk_flag;
        rd_mux[`FAC_BIT_PROG_UNLK] = prog_unlk_flag;
        rd_mux[`FAC_BIT_DATA_UNLK] = data_unlk_flag;
      end
      `FAC_OFS_SPLIT:      rd_mux = split_q;
      `FAC_OFS_PTR_LO:     rd_mux = ptr_q[7:0];
      `FAC_OFS_PTR_HI:     rd_mux = {2'b00, ptr_q[13:8]};
      default:             rd_mux = 8'h00;
    endcase
    if (rd_port && !(read_op && op_ok)) begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ----------------------------------------
  // flash sleep
  // ----------------------------------------
  // follows the chip low-power level, so wake needs no extra handshake
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_en_q && i_chip_lowpower;
    end
  end

  logic busy_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (start_erase || start_prog) || (!idle && (cnt_q != PAGE_AW'(PAGE_BYTES - 1)));
    end
  end

  assign o_rdata       = rdata_q;
  assign o_busy        = busy_q;
  assign o_flash_sleep = sleep_q;

endmodule // fac_flash_ctrl

`default_nettype wire

//--- fac_ctrl_assertions.sv
/*
  concurrent checks on the ports of the flash area controller.
  assumes one clock and an active-low asynchronous reset; bound to fac_flash_ctrl.
*/
`default_nettype none

module fac_ctrl_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_chip_lowpower,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_busy,
  input wire logic        o_flash_sleep
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic       pwr6_q;
  logic [6:0] bcnt_q;

  // power writes act even while busy, so no busy gate here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pwr6_q <= 1'b0;
    else if (i_wr && i_addr == 16'hFC00) pwr6_q <= i_wdata[6];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) bcnt_q <= 7'h00;
    else bcnt_q <= o_busy ? bcnt_q + 7'h01 : 7'h00;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_sleep_follow: assert property (o_flash_sleep == $past(pwr6_q & i_chip_lowpower))
    else $error("flash sleep does not follow power bit and low power");
  a_busy_bound: assert property (o_busy |-> bcnt_q < 7'h40)
    else $error("sequence runs past one 64-byte unit");
  a_busy_length: assert property ($fell(o_busy) |-> $past(bcnt_q) == 7'h3F)
    else $error("sequence not exactly 64 cycles long");
  a_busy_cause: assert property ($rose(o_busy) |-> $past(i_wr && i_addr == 16'hFC01 &&
    i_wdata[2:0] inside {3'h2, 3'h3, 3'h4, 3'h6, 3'h7})) else $error("sequence started without command");
  a_unmapped_zero: assert property (i_rd && (i_addr < 16'hFC00 || i_addr > 16'hFC06) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_lock_shape: assert property (i_rd && i_addr == 16'hFC03 |=> o_rdata[7:4] == 4'h0 && !o_rdata[0] &&
    o_rdata[3] == (o_rdata[2] | o_rdata[1])) else $error("lock flags malformed");
  a_cmd_reserved: assert property (i_rd && i_addr == 16'hFC01 |=> o_rdata[6:3] == 4'h0)
    else $error("command reserved or latch clear bits read nonzero");
  a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data changed without read");
  a_lock_all: assert property ((i_wr && i_addr == 16'hFC03 && i_wdata == 8'hAA) ##1
    (i_rd && i_addr == 16'hFC03) |=> o_rdata == 8'h00) else $error("lock key left an area open");
  a_unlock_data: assert property ((i_wr && i_addr == 16'hFC03 && i_wdata == 8'h2A) ##1
    (i_rd && i_addr == 16'hFC03) |=> o_rdata[1] && o_rdata[3]) else $error("data key did not unlock");
endmodule // fac_ctrl_assertions

bind fac_flash_ctrl fac_ctrl_assertions chk_u (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
  .i_chip_lowpower(i_chip_lowpower), .o_rdata(o_rdata), .o_busy(o_busy), .o_flash_sleep(o_flash_sleep)
);

`default_nettype wire

//--- test_flash_area_controller.sv
/*
  register-level testbench of the flash area controller.
  assumes the single-cycle strobe bus of fac_flash_ctrl; array cells start unknown.
*/
`default_nettype none

module test_flash_area_controller;
  timeunit 1ns;
  timeprecision 100ps;

  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_chip_lowpower = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_busy;
  logic        o_flash_sleep;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [7:0]  rst_tab [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

  always #2.5 i_clk = ~i_clk;

  fac_flash_ctrl dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
    .i_chip_lowpower(i_chip_lowpower), .o_rdata(o_rdata), .o_busy(o_busy), .o_flash_sleep(o_flash_sleep)
  );

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  // data lands on the edge after the strobe; sampled one edge later, where it holds
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    chk($sformatf("read %h", a), e, o_rdata);
  endtask

  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wait_idle(input logic eb);
    idle(1);
    chk("busy", {7'h00, eb}, {7'h00, o_busy});
    repeat (100) begin
      if (o_busy === 1'b0) break;
      @(posedge i_clk);
    end
  endtask

  task automatic setp(input logic [13:0] p);
    wr(16'hFC06, {2'b00, p[13:8]});
    wr(16'hFC05, p[7:0]);
  endtask

  task automatic rd_blk(input logic [7:0] x, input logic inc);
    for (int i = 0; i < 64; i++) rd(16'hFC02, inc ? (8'(i) ^ x) : x);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    // top down: the pointer is read before a data-port read advances it
    for (int i = 7; i >= 0; i--) rd(16'hFC00 + 16'(i), rst_tab[i]);
    $display("test reset done");
    wr(16'hFC03, 8'h2A);
    rd(16'hFC03, 8'h0A);
    wr(16'hFC03, 8'h29);
    rd(16'hFC03, 8'h0E);
    wr(16'hFC03, 8'hAA);
    rd(16'hFC03, 8'h00);
    wr(16'hFC03, 8'h55);
    rd(16'hFC03, 8'h00);
    wr(16'hFC03, 8'h2A);
    $display("test keys done");
    wr(16'hFC04, 8'h02);
    setp(14'h0000);
    wr(16'hFC01, 8'h03);
    wait_idle(1'b1);
    rd(16'hFC01, 8'h00);
    setp(14'h0040);
    wr(16'hFC01, 8'h03);
    wait_idle(1'b1);
    wr(16'hFC01, 8'h08);
    setp(14'h0000);
    for (int i = 0; i < 64; i++) wr(16'hFC02, 8'(i) ^ 8'h5A);
    setp(14'h0040);
    wr(16'hFC01, 8'h02);
    wait_idle(1'b1);
    rd(16'hFC01, 8'h02);
    setp(14'h0000);
    wr(16'hFC01, 8'h03);
    wait_idle(1'b1);
    wr(16'hFC01, 8'h01);
    setp(14'h0000);
    rd_blk(8'hFF, 1'b0);
    rd_blk(8'h5A, 1'b1);
    rd(16'hFC05, 8'h80);
    $display("test data area done");
    wr(16'hFC03, 8'h29);
    setp(14'h0000);
    wr(16'hFC01, 8'h07);
    wait_idle(1'b1);
    wr(16'hFC01, 8'h05);
    setp(14'h0000);
    rd(16'hFC02, 8'hFF);
    setp(14'h0140);
    rd(16'hFC02, 8'h00);
    wr(16'hFC01, 8'h04);
    wait_idle(1'b1);
    wr(16'hFC01, 8'h01);
    setp(14'h0040);
    rd(16'hFC02, 8'hFF);
    setp(14'h0080);
    wr(16'hFC01, 8'h06);
    wait_idle(1'b1);
    wr(16'hFC01, 8'h05);
    setp(14'h0090);
    rd(16'hFC02, 8'h4A);
    $display("test program area done");
    wr(16'hFC04, 8'h00);
    setp(14'h0000);
    wr(16'hFC01, 8'h07);
    wait_idle(1'b0);
    rd(16'hFC01, 8'h00);
    wr(16'hFC01, 8'h01);
    setp(14'h0000);
    rd(16'hFC02, 8'hFF);
    wr(16'hFC03, 8'hAA);
    wr(16'hFC01, 8'h03);
    wait_idle(1'b0);
    wr(16'hFC01, 8'h01);
    setp(14'h0000);
    rd(16'hFC02, 8'h00);
    wr(16'hFC01, 8'h88);
    rd(16'hFC01, 8'h80);
    $display("test split and lock done");
    wr(16'hFC00, 8'hC0);
    i_chip_lowpower <= 1'b1;
    idle(2);
    chk("sleep", 8'h01, {7'h00, o_flash_sleep});
    i_chip_lowpower <= 1'b0;
    idle(2);
    chk("sleep", 8'h00, {7'h00, o_flash_sleep});
    rd(16'hFC00, 8'h40);
    $display("test sleep done");
    wrap_up();
  end

  // the whole sequence needs about 900 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    wrap_up();
  end
endmodule // test_flash_area_controller

`default_nettype wire
